//--- src/dacdu_top.sv
`timescale 1ns/100ps
module dacdu_top
    import dacdu_pkg::*;
(
    // clock, reset, enable
    input  wire logic       i_core_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_ce,
    // write path from the serial slave
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_last_byte,
    input  wire logic       i_ack_clk,
    // read-back and wiper outputs
    output logic      [6:0] o_rd_value,
    output logic      [6:0] o_wiper_code,
    output logic            o_update
);
    // ack pin synchroniser: first stage read only by second
    logic [SYNC_STAGES-1:0] ack_sync_reg;
    // edge-detector state, one flop behind the synchroniser
    dacdu_ack_t             ack_state_reg;
    // stored value, the only state that can be read back
    logic [VAL_W-1:0]       value_reg;
    // candidate value, seven low bits of the synchronised byte
    logic [VAL_W-1:0]       value_next;
    // decoder output, combinational from the stored value
    logic [VAL_W-1:0]       code_comb;
    // registered copy of the code, drives the ladder
    logic [VAL_W-1:0]       code_reg;
    // one-cycle marker of a fresh capture
    logic                   update_reg;
    // data and final-byte flag ride through the same two stages as the
    // ack pin; they are only trusted because the slave holds them steady
    // for several cycles either side of the ack fall
    logic [DATA_W-1:0]      data_sync_reg [SYNC_STAGES];
    logic [SYNC_STAGES-1:0] last_sync_reg;

    // synchronised ack level, the only stage that logic may read
    wire ack_level   = ack_sync_reg[SYNC_STAGES-1];
    // falling edge: the state still remembers high, the level is low now
    wire ack_fall    = (ack_state_reg == DACDU_ACK_HIGH) && !ack_level;
    // final flag seen in the same sample as the edge
    wire last_seen   = last_sync_reg[SYNC_STAGES-1];
    // capture strobe, the one event besides reset that moves the value
    wire do_load     = ack_fall && last_seen;
    // refused edge: ack fell but the byte was not the last one
    wire ack_refused = ack_fall && !last_seen;
    // seven low bits only, the top bit is thrown away
    assign value_next = data_sync_reg[SYNC_STAGES-1][VAL_W-1:0];

    // two-flop synchronisers for pin-side inputs; the extra latency
    // costs nothing since the ack pulse spans several cycles
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            // idle levels, so no false edge follows reset
            ack_sync_reg  <= '0;
            last_sync_reg <= '0;
            data_sync_reg <= '{default: 8'h00};
        end else if (i_ce) begin
            // shift one stage per enabled edge
            ack_sync_reg  <= {ack_sync_reg[0], i_ack_clk};
            last_sync_reg <= {last_sync_reg[0], i_last_byte};
            data_sync_reg <= '{i_wr_data, data_sync_reg[0]};
        end
    end

    // edge-detector state follows the synchronised level
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            // starts low, matching the idle pin
            ack_state_reg <= DACDU_ACK_LOW;
        end else if (i_ce) begin
            case (ack_level)
                // pulse in progress
                1'b1:    ack_state_reg <= DACDU_ACK_HIGH;
                // idle or just fallen
                default: ack_state_reg <= DACDU_ACK_LOW;
            endcase
        end
    end

    // stored value: reset to mid-scale, else only on the final ack edge;
    // a write cut short before its last byte leaves it untouched
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            value_reg <= SVR_RESET;
        end else if (i_ce && do_load) begin
            value_reg <= value_next;
        end
    end

    // range decoder, kept apart so it can be checked on its own
    dacdu_decode dacdu_decode_i (
        .i_value (value_reg),
        .o_code  (code_comb)
    );

    // outputs registered so every port comes from a flop; the code
    // therefore trails the stored value by one enabled edge
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            // mid-scale code, matching the reset value
            code_reg   <= CODE_RESET;
            update_reg <= 1'b0;
        end else if (i_ce) begin
            code_reg   <= code_comb;
            update_reg <= do_load;
        end
    end

    // read-back is the stored value, never the decoded code
    assign o_rd_value   = value_reg;
    assign o_wiper_code = code_reg;
    assign o_update     = update_reg;

    // checks: all on the core clock, quiet while reset is held except AST_RESET, which checks reset

    // the code never leaves the 65-position ladder
    AST_RANGE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_wiper_code <= CODE_FULL) else $error("wiper code above 64");

    // top band saturates at full scale
    AST_FULL: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_ce && value_reg >= FS_BOTTOM |=> o_wiper_code == CODE_FULL)
        else $error("full scale decode wrong");

    // bottom band pins to zero scale
    AST_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_ce && value_reg <= ZS_TOP |=> o_wiper_code == CODE_ZERO)
        else $error("zero scale decode wrong");

    // middle band is a plain offset subtraction
    AST_MID: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_ce && value_reg > ZS_TOP && value_reg < FS_BOTTOM
        |=> o_wiper_code == $past(value_reg) - CODE_OFFSET)
        else $error("offset decode wrong");

    // a capture takes the synchronised byte
    AST_LOAD: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_ce && do_load |=> value_reg == $past(value_next))
        else $error("value not captured");

    // nothing but a capture moves the stored value
    AST_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !(i_ce && do_load) |=> $stable(value_reg)) else $error("value changed");

    // stored bits match the pin three enabled edges back, bit 7 gone
    AST_MSB: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_ce && $past(i_ce) && $past(i_ce, 2) && do_load
        |=> value_reg == $past(i_wr_data[6:0], 3))
        else $error("msb not dropped");

    // reset lands mid-scale on the value, read-back and code, with the update pulse low
    AST_RESET: assert property (@(posedge i_core_clk)
        !i_resetn |=> value_reg == SVR_RESET && o_rd_value == SVR_RESET
            && o_wiper_code == CODE_RESET && !o_update)
        else $error("reset value wrong");

    // read-back moves only at a capture edge
    AST_READ: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        $changed(o_rd_value) |-> $past(i_ce && do_load))
        else $error("read-back moved alone");

    // code follows the value one enabled edge later, never alone
    AST_CODE_FOLLOW: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_ce && $past(i_ce) && $stable(value_reg) |=> $stable(o_wiper_code))
        else $error("code moved alone");

    // each capture is announced by an update pulse
    AST_UPDATE_PULSE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_ce && do_load |=> o_update)
        else $error("update pulse missing");

    // the pulse never stretches while the clock is enabled
    AST_UPDATE_ONE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_ce && o_update |=> !o_update)
        else $error("update pulse too long");

    // an enabled pulse always traces back to a capture
    AST_UPDATE_ONLY: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        $past(i_ce) && o_update |-> $past(do_load))
        else $error("update without capture");

    // an ack edge with the final flag low leaves the value alone
    AST_NOT_LAST: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_ce && ack_refused |=> $stable(value_reg))
        else $error("non-final byte captured");

    // capture fires only where the ack pin went from high to low
    AST_ACK_EDGE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_ce && $past(i_ce) && $past(i_ce, 2) && $past(i_ce, 3) && do_load
        |-> !$past(i_ack_clk, 2) && $past(i_ack_clk, 3))
        else $error("capture without ack fall");

    // capture needs the final-byte flag in the same sample
    AST_LAST_GATE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_ce && $past(i_ce) && $past(i_ce, 2) && do_load |-> $past(i_last_byte, 2))
        else $error("capture without final byte");

    // main scenarios: capture, both saturated ends, middle band, refusal
    COV_LOAD: cover property (@(posedge i_core_clk) disable iff (!i_resetn) do_load && i_ce);

    // full-scale code reached
    COV_FULL: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_wiper_code == CODE_FULL);

    // zero-scale code reached
    COV_ZERO: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_wiper_code == CODE_ZERO);

    // capture of a value in the offset band
    COV_MID: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_ce && do_load && value_next > ZS_TOP && value_next < FS_BOTTOM);

    // ack edge refused for a byte that was not the last
    COV_REFUSED: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_ce && ack_refused);
endmodule // dacdu_top

//--- src/dacdu_pkg.sv
package dacdu_pkg;
    // widths of the stored value and wiper code, and of the write byte
    localparam int VAL_W  = 7;
    localparam int DATA_W = 8;
    // stored value reset to mid-scale
    localparam logic [6:0] SVR_RESET    = 7'h40;
    // decode boundaries and offset
    localparam logic [6:0] ZS_TOP       = 7'h20;
    localparam logic [6:0] FS_BOTTOM    = 7'h60;
    localparam logic [6:0] CODE_OFFSET  = 7'h20;
    localparam logic [6:0] CODE_ZERO    = 7'h00;
    localparam logic [6:0] CODE_FULL    = 7'h40;
    // code after reset, mid-scale to match the stored value
    localparam logic [6:0] CODE_RESET   = 7'h20;
    // synchroniser depth for the ack pin, write byte and final-byte flag
    localparam int SYNC_STAGES = 2;

    // capture-edge detector states
    typedef enum logic [0:0] {
        DACDU_ACK_LOW  = 1'b0,
        DACDU_ACK_HIGH = 1'b1
    } dacdu_ack_t;
endpackage : dacdu_pkg

//--- src/dacdu_decode.sv
`timescale 1ns/100ps
module dacdu_decode
    import dacdu_pkg::*;
(
    // stored value in
    input  wire logic [6:0] i_value,
    // wiper code out
    output logic      [6:0] o_code
);
    // range classification wires
    wire       is_zero = (i_value <= ZS_TOP);
    wire       is_full = (i_value >= FS_BOTTOM);
    wire [6:0] offset  = i_value - CODE_OFFSET;

    // purely combinational, so code moves only with the stored value
    assign o_code = is_full ? CODE_FULL : (is_zero ? CODE_ZERO : offset);
endmodule // dacdu_decode

//--- test/dacdu_master.sv
`timescale 1ns/100ps
module dacdu_master (
    // bench clock
    input  wire logic       i_core_clk,
    // write path toward the device
    output logic      [7:0] o_data,
    output logic            o_last,
    output logic            o_ack
);
    // idle until the first byte
    initial begin
        o_data = 8'h00;
        o_last = 1'b0;
        o_ack  = 1'b0;
    end
    // one byte: data held 4 cycles either side of the ack fall, then scrambled
    task automatic send(input logic [7:0] d, input logic l);
        @(negedge i_core_clk);
        o_data = d;
        o_last = l;
        o_ack  = 1'b1;
        repeat (4) @(negedge i_core_clk);
        o_ack  = 1'b0;
        repeat (4) @(negedge i_core_clk);
        o_data = ~d;
        o_last = 1'b0;
    endtask
endmodule // dacdu_master

//--- test/dac_code_decode_update_test.sv
`timescale 1ns/100ps
module dac_code_decode_update_test;
    logic       clk          = 1'b0; // bench clock
    logic       resetn       = 1'b0; // reset, active low
    logic       ce           = 1'b1; // clock enable
    logic [7:0] data;                // master byte
    logic       last;                // last byte flag
    logic       ack;                 // ack pulse
    logic [6:0] rd_value;            // stored value
    logic [6:0] code;                // wiper code
    logic       update;              // update pulse
    logic [6:0] exp_val;             // expected stored value
    int         n_mismatch   = 0;    // failed compares
    int         total_checks = 0;    // all compares
    int         n_update     = 0;    // pulses seen
    logic [7:0] bytes [9] = '{8'hC5, 8'h00, 8'h20, 8'h21, 8'hA1, 8'h5F, 8'h60, 8'hFF, 8'hC0};
    always #5 clk = ~clk;
    // count update pulses; one per accepted write
    always @(posedge clk) if (update === 1'b1) n_update <= n_update + 1;
    dacdu_top dacdu_top_i (.i_core_clk(clk), .i_resetn(resetn), .i_ce(ce),
        .i_wr_data(data), .i_last_byte(last), .i_ack_clk(ack),
        .o_rd_value(rd_value), .o_wiper_code(code), .o_update(update));
    dacdu_master dacdu_master_i (.i_core_clk(clk), .o_data(data), .o_last(last), .o_ack(ack));
    task automatic chk(input logic [6:0] got, input logic [6:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // bench copy of the decode, written from the ranges
    function automatic logic [6:0] dec(input logic [6:0] v);
        return (v <= 7'h20) ? 7'h00 : (v >= 7'h60) ? 7'h40 : v - 7'h20;
    endfunction
    // reset held 12 cycles, then mid-scale expected
    task automatic reset_check();
        resetn = 1'b0;
        repeat (12) @(negedge clk);
        resetn  = 1'b1;
        exp_val = 7'h40;
        chk(rd_value, 7'h40);
        chk(code, 7'h20);
    endtask
    // one write; a byte without the last flag must change nothing
    task automatic write_check(input logic [7:0] d, input logic l);
        int n0;
        n0 = n_update;
        if (l) exp_val = d[6:0];
        dacdu_master_i.send(d, l);
        repeat (4) @(negedge clk);
        chk(rd_value, exp_val);
        chk(code, dec(exp_val));
        chk(7'(n_update - n0), {6'h00, l});
    endtask
    // enable low through a whole final-byte write: nothing may move
    task automatic freeze_check();
        int n0;
        n0 = n_update;
        @(negedge clk);
        ce = 1'b0;
        dacdu_master_i.send(8'h55, 1'b1);
        repeat (4) @(negedge clk);
        ce = 1'b1;
        repeat (8) @(negedge clk);
        chk(rd_value, exp_val);
        chk(code, dec(exp_val));
        chk(7'(n_update - n0), 7'h00);
    endtask
    initial begin
        reset_check();
        foreach (bytes[k]) write_check(bytes[k], 1'b1);
        write_check(8'h30, 1'b0);
        freeze_check();
        reset_check();
        write_check(8'hDE, 1'b1);
        finish_test();
    end
endmodule // dac_code_decode_update_test
